// *** hdl/rvc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module rvc_regs
  import rvc_pkg::*;
#(
  parameter int ADR_W    = 12,
  parameter int STEP_CYC = RAMP_STEP_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic                   wb_ack_o,
  output logic      [31:0]       wb_dat_o,
  input  wire logic              power_down_i,
  output logic                   lin_ten_on_o,
  output logic      [CODE_W-1:0] lin_ten_code_o,
  output logic      [11:0]       lin_ten_mv_o,
  output logic      [CODE_W-1:0] core_buck_code_o,
  output logic      [CODE_W-1:0] proc_buck_code_o,
  output logic      [CODE_W-1:0] memory_buck_code_o,
  output logic      [CODE_W-1:0] lin_two_code_o,
  output logic      [CODE_W-1:0] lin_three_code_o,
  output logic                   core_buck_force_pwm_o,
  output logic                   proc_buck_force_pwm_o,
  output logic                   memory_buck_force_pwm_o
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // code to millivolts, codes above the top step stay at 3.60 V
  function automatic logic [11:0] code_to_mv(input logic [CODE_W-1:0] c);
    logic [CODE_W-1:0] lim;
    lim = (c > CODE_MAX) ? CODE_MAX : c;
    return 12'(MV_BASE + 12'({6'h00, lim}) * MV_STEP);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic              ack_r, ack_nxt;          // bus answer
  logic [31:0]       rdat_r, rdat_nxt;        // read data
  logic [7:0]        ten_r, ten_nxt;          // ten control register
  logic [7:0]        sup_r, sup_nxt;          // supply register
  logic [7:0]        rail_r   [NUM_RAILS];    // rail voltage registers
  logic [7:0]        rail_nxt [NUM_RAILS];
  logic [CODE_W-1:0] appl_r   [NUM_RAILS];    // applied rail codes
  logic [CODE_W-1:0] appl_nxt [NUM_RAILS];
  logic [CODE_W-1:0] ten_out_r, ten_out_nxt;  // applied ten code
  logic              ten_on_r, ten_on_nxt;    // regulator on output
  logic [11:0]       mv_r, mv_nxt;            // millivolt output
  logic [2:0]        pwm_r, pwm_nxt;          // forced pwm outputs
  logic [15:0]       tick_cnt_r, tick_cnt_nxt;  // ramp step divider
  logic              tick_r, tick_nxt;        // step enable pulse
  logic              pd_s1_r, pd_s2_r, pd_s3_r;  // power-down sync
  logic              pd_r, pd_nxt;            // filtered power-down

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [7:0] idx;                            // register index
  logic       acc;                            // new access this cycle
  logic       wr;                             // write on byte lane 0
  logic [NUM_RAILS-1:0] go_set;               // software go requests
  assign idx = wb_adr_i[9:2];
  assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr  = acc & wb_we_i & wb_sel_i[0];

  // ****************************************************************
  // power-down input synchroniser
  // ****************************************************************
  // the filtered level follows once the second and third stages agree
  always_comb begin
    pd_nxt = (pd_s2_r == pd_s3_r) ? pd_s3_r : pd_r;
  end

  // three stage capture of the asynchronous power-down level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
      pd_s3_r <= 1'b0;
      pd_r    <= 1'b0;
    end else begin
      pd_s1_r <= power_down_i;
      pd_s2_r <= pd_s1_r;
      pd_s3_r <= pd_s2_r;
      pd_r    <= pd_nxt;
    end
  end

  // ****************************************************************
  // ramp step divider
  // ****************************************************************
  // counts clock cycles and pulses tick_r once per ramp step
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 16'h0001;
    if (tick_cnt_r == 16'(STEP_CYC - 1)) begin
      tick_cnt_nxt = 16'h0000;
      tick_nxt     = 1'b1;
    end
  end

  // divider state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ****************************************************************
  // registers, ramps and bus answer
  // ****************************************************************
  // next values of registers, applied codes and outputs
  always_comb begin
    ack_nxt  = acc;
    rdat_nxt = 32'h0000_0000;
    ten_nxt  = ten_r;
    sup_nxt  = sup_r;
    go_set   = '0;
    for (int i = 0; i < NUM_RAILS; i++) begin
      rail_nxt[i] = rail_r[i];
      appl_nxt[i] = appl_r[i];
    end
    // read mux, unmapped indices read zero but still answer
    if (acc && !wb_we_i) begin
      case (idx)
        IDX_TEN_CTRL:  rdat_nxt = {24'h0, ten_r};
        IDX_SUPPLY:    rdat_nxt = {24'h0, sup_r};
        IDX_CORE_BUCK: rdat_nxt = {24'h0, rail_r[RAIL_CORE]};
        IDX_PROC_BUCK: rdat_nxt = {24'h0, rail_r[RAIL_PROC]};
        IDX_MEM_BUCK:  rdat_nxt = {24'h0, rail_r[RAIL_MEM]};
        IDX_LIN_TWO:   rdat_nxt = {24'h0, rail_r[RAIL_TWO]};
        IDX_LIN_THREE: rdat_nxt = {24'h0, rail_r[RAIL_THREE]};
        default:       rdat_nxt = 32'h0000_0000;
      endcase
    end
    // ramps: step toward target on tick, go clears at target
    for (int i = 0; i < NUM_RAILS; i++) begin
      if (sup_r[i]) begin
        if (appl_r[i] == rail_r[i][CODE_W-1:0]) begin
          sup_nxt[i] = 1'b0;
        end else if (tick_r) begin
          if (appl_r[i] < rail_r[i][CODE_W-1:0]) begin
            appl_nxt[i] = appl_r[i] + 6'h01;
          end else begin
            appl_nxt[i] = appl_r[i] - 6'h01;
          end
        end
      end
    end
    // writes
    if (wr) begin
      case (idx)
        IDX_TEN_CTRL: begin
          ten_nxt[BIT_PRESET] = wb_dat_i[BIT_PRESET];
          ten_nxt[BIT_ON]     = wb_dat_i[BIT_ON];
          if (!sup_r[BIT_LOCK]) begin
            ten_nxt[CODE_W-1:0] = wb_dat_i[CODE_W-1:0];
          end
        end
        IDX_SUPPLY: begin
          sup_nxt[7:5] = wb_dat_i[7:5];
          // go bits only start, set wins over a same-cycle clear
          go_set[RAIL_CORE] = wb_dat_i[RAIL_CORE];
          go_set[RAIL_PROC] = wb_dat_i[RAIL_PROC];
          go_set[RAIL_MEM]  = wb_dat_i[RAIL_MEM];
          go_set[RAIL_TWO]   = wb_dat_i[RAIL_TWO] & ~rail_r[RAIL_TWO][BIT_PRESET];
          go_set[RAIL_THREE] = wb_dat_i[RAIL_THREE] & ~rail_r[RAIL_THREE][BIT_PRESET];
          for (int i = 0; i < NUM_RAILS; i++) begin
            if (go_set[i]) begin
              sup_nxt[i] = 1'b1;
            end
          end
        end
        default: begin
          // rail voltage registers: blocked while ramping, code field kept while locked
          for (int i = 0; i < NUM_RAILS; i++) begin
            if (idx == 8'(IDX_CORE_BUCK + 8'(i)) && !sup_r[i]) begin
              if (i >= RAIL_TWO) begin
                rail_nxt[i][BIT_PRESET] = wb_dat_i[BIT_PRESET];
              end
              if (!sup_r[BIT_LOCK]) begin
                rail_nxt[i][CODE_W-1:0] = wb_dat_i[CODE_W-1:0];
              end
            end
          end
        end
      endcase
    end
    // ten regulator: immediate code, or preset used at power-down
    ten_out_nxt = ten_out_r;
    if (!ten_r[BIT_PRESET] || pd_r) begin
      ten_out_nxt = ten_r[CODE_W-1:0];
    end
    ten_on_nxt = ten_r[BIT_ON] & (~pd_r | ten_r[BIT_PRESET]);
    mv_nxt     = code_to_mv(ten_out_nxt);
    pwm_nxt    = sup_nxt[RAIL_MEM:RAIL_CORE];
  end

  // registers every next value, reset loads the documented reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r     <= 1'b0;
      rdat_r    <= 32'h0000_0000;
      ten_r     <= RST_TEN_CTRL;
      sup_r     <= RST_SUPPLY;
      ten_out_r <= RST_TEN_CTRL[CODE_W-1:0];
      ten_on_r  <= 1'b0;
      // reset code taken through base and step, without the 3.60 V cap used in operation
      mv_r      <= 12'(MV_BASE + 12'(RST_TEN_CTRL[CODE_W-1:0]) * MV_STEP);
      pwm_r     <= 3'h0;
      for (int i = 0; i < NUM_RAILS; i++) begin
        rail_r[i] <= RST_RAIL;
        appl_r[i] <= RST_RAIL[CODE_W-1:0];
      end
    end else begin
      ack_r     <= ack_nxt;
      rdat_r    <= rdat_nxt;
      ten_r     <= ten_nxt;
      sup_r     <= sup_nxt;
      ten_out_r <= ten_out_nxt;
      ten_on_r  <= ten_on_nxt;
      mv_r      <= mv_nxt;
      pwm_r     <= pwm_nxt;
      for (int i = 0; i < NUM_RAILS; i++) begin
        rail_r[i] <= rail_nxt[i];
        appl_r[i] <= appl_nxt[i];
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o                = ack_r;
  assign wb_dat_o                = rdat_r;
  assign lin_ten_on_o            = ten_on_r;
  assign lin_ten_code_o          = ten_out_r;
  assign lin_ten_mv_o            = mv_r;
  assign core_buck_code_o        = appl_r[RAIL_CORE];
  assign proc_buck_code_o        = appl_r[RAIL_PROC];
  assign memory_buck_code_o      = appl_r[RAIL_MEM];
  assign lin_two_code_o          = appl_r[RAIL_TWO];
  assign lin_three_code_o        = appl_r[RAIL_THREE];
  assign core_buck_force_pwm_o   = pwm_r[RAIL_CORE];
  assign proc_buck_force_pwm_o   = pwm_r[RAIL_PROC];
  assign memory_buck_force_pwm_o = pwm_r[RAIL_MEM];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_core;
    wr && idx == IDX_CORE_BUCK;
  endsequence
  sequence s_wr_ten;
    wr && idx == IDX_TEN_CTRL;
  endsequence

  AST_TEN_MV_CAP: assert property (lin_ten_mv_o <= 12'hE10)
    else $error("ten millivolts above 3600");
  AST_TEN_OFF: assert property (!ten_r[BIT_ON] |=> !lin_ten_on_o)
    else $error("ten regulator on while disabled");
  AST_TEN_HOLD: assert property (ten_r[BIT_PRESET] && !pd_r |=> $stable(lin_ten_code_o))
    else $error("preset code applied outside power-down");
  AST_CORE_HOLD: assert property (!sup_r[RAIL_CORE] |=> $stable(core_buck_code_o))
    else $error("core buck moved without go");
  AST_PROC_HOLD: assert property (!sup_r[RAIL_PROC] |=> $stable(proc_buck_code_o))
    else $error("processor buck moved without go");
  AST_MEM_HOLD: assert property (!sup_r[RAIL_MEM] |=> $stable(memory_buck_code_o))
    else $error("memory buck moved without go");
  AST_PROC_PWM: assert property (sup_r[RAIL_PROC] |-> proc_buck_force_pwm_o)
    else $error("processor buck not forced pwm while ramping");
  AST_TEN_PD_OFF: assert property (pd_r && !ten_r[BIT_PRESET] |=> !lin_ten_on_o)
    else $error("ten regulator left on in power-down without preset");
  AST_GO_CLEAR: assert property (sup_r[RAIL_PROC] && appl_r[RAIL_PROC] == rail_r[RAIL_PROC][5:0]
    && !go_set[RAIL_PROC] |=> !sup_r[RAIL_PROC])
    else $error("go bit stuck at target");
  AST_CORE_BLOCK: assert property (s_wr_core and sup_r[RAIL_CORE] |=> $stable(rail_r[RAIL_CORE]))
    else $error("core buck written during ramp");
  AST_PWM: assert property (sup_r[RAIL_MEM] |-> ##[0:1] memory_buck_force_pwm_o)
    else $error("memory buck not forced pwm");
  AST_PRESET_IGN: assert property (wr && idx == IDX_SUPPLY && !sup_r[RAIL_TWO]
    && rail_r[RAIL_TWO][BIT_PRESET] |=> !sup_r[RAIL_TWO])
    else $error("linear two ramp started while preset");
  AST_LOCK: assert property (s_wr_ten and sup_r[BIT_LOCK] |=> $stable(ten_r[5:0]))
    else $error("ten code rewritten while locked");
  // bus answer is a single-cycle pulse
  AST_ACK: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : rvc_regs
`default_nettype wire

// *** pkg/rvc_pkg.sv ***
// What this block does
// - bit 7 holds code as power-down preset
// - core go bit ramps core buck
// - processor go bit ramps processor buck
// - memory go bit ramps memory buck
// - go bit clears when target reached
// - voltage writes ignored while that rail ramps
// - ramping buck forced into pwm
// - linear two/three go, ignored when preset
// - lock bit blocks voltage code rewrites
package rvc_pkg;
  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_TEN_CTRL   = 8'h3B;  // linear_reg_ten_ctrl
  localparam logic [7:0] IDX_SUPPLY     = 8'h3C;  // supply_ramp_ctrl
  localparam logic [7:0] IDX_CORE_BUCK  = 8'h40;  // core buck voltage
  localparam logic [7:0] IDX_PROC_BUCK  = 8'h41;  // processor buck voltage
  localparam logic [7:0] IDX_MEM_BUCK   = 8'h42;  // memory buck voltage
  localparam logic [7:0] IDX_LIN_TWO    = 8'h43;  // linear two voltage
  localparam logic [7:0] IDX_LIN_THREE  = 8'h44;  // linear three voltage
  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         CODE_W         = 6;      // voltage code width
  localparam int         BIT_ON         = 6;      // ten regulator on
  localparam int         BIT_PRESET     = 7;      // preset select
  localparam int         BIT_LOCK       = 7;      // voltage lock
  localparam int         NUM_RAILS      = 5;      // ramped rails
  localparam int         RAIL_CORE      = 0;      // core buck go bit
  localparam int         RAIL_PROC      = 1;      // processor buck go bit
  localparam int         RAIL_MEM       = 2;      // memory buck go bit
  localparam int         RAIL_TWO       = 3;      // linear two go bit
  localparam int         RAIL_THREE     = 4;      // linear three go bit
  localparam logic [7:0] RST_TEN_CTRL   = 8'h21;  // code 100001, off
  localparam logic [7:0] RST_SUPPLY     = 8'h60;  // switches closed
  localparam logic [7:0] RST_RAIL       = 8'h00;  // own rail registers
  // ****************************************************************
  // voltage mapping in millivolts
  // ****************************************************************
  localparam logic [11:0] MV_BASE       = 12'h4B0;  // 1200 mV
  localparam logic [11:0] MV_STEP       = 12'h032;  // 50 mV
  localparam logic [5:0]  CODE_MAX      = 6'h30;    // 3.60 V code
  // ****************************************************************
  // ramp step timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;    // 40 MHz
  localparam int RAMP_STEP_NS  = 1000;  // time per code step
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rvc_pkg

// *** dv/regulator_voltage_ctrl_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// register bank bench, driven over a classic wishbone master
// ************************************************************
module regulator_voltage_ctrl_regs_test;
  import rvc_pkg::*;
  localparam int  STEP = 4;                // short ramp tick for the run
  logic           clk_i = 1'b0;            // 40 MHz bench clock
  logic           rst_i = 1'b1;            // sync reset, active high
  logic           cyc = 1'b0, stb = 1'b0;  // wishbone request
  logic           we = 1'b0;               // wishbone direction
  logic [11:0]    adr = 12'h000;           // byte address
  logic [3:0]     sel = 4'h0;              // wishbone byte lanes
  logic [31:0]    wdat = 32'h0;            // write data
  logic           pd = 1'b0;               // power-down sequence level
  wire logic      ack, ten_on;             // answer and ten regulator on
  wire logic [31:0] rdat;                  // read data
  wire logic [5:0] ten_code;               // applied ten code
  wire logic [11:0] ten_mv;                // applied ten millivolts
  wire logic [5:0] rail [5];               // applied ramped codes
  wire logic [2:0] pwm;                    // forced pwm per buck
  int             fails = 0, cmp_count = 0;
  logic [31:0]    d;                       // last read word

  rvc_regs #(.ADR_W(12), .STEP_CYC(STEP)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .power_down_i(pd), .lin_ten_on_o(ten_on), .lin_ten_code_o(ten_code),
    .lin_ten_mv_o(ten_mv), .core_buck_code_o(rail[0]), .proc_buck_code_o(rail[1]),
    .memory_buck_code_o(rail[2]), .lin_two_code_o(rail[3]), .lin_three_code_o(rail[4]),
    .core_buck_force_pwm_o(pwm[0]), .proc_buck_force_pwm_o(pwm[1]),
    .memory_buck_force_pwm_o(pwm[2]));

  // clock toggles every half period
  always #12.5 clk_i = ~clk_i;

  // ************************************************************
  // helpers
  // ************************************************************
  // wait n edges; outputs read here hold what the previous edge launched
  task automatic cw(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // compare one value, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle: raised after an edge, held until the edge that samples
  // ack high, read data taken at that edge, released right after it
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'hF;
    adr  <= {2'b00, idx, 2'b00};
    wdat <= {24'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fails++;
      conclude();
    end
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  // expected millivolts of a ten code
  function automatic logic [11:0] mv(input int c);
    return 12'(1200 + 50 * ((c > 48) ? 48 : c));
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset values and an unmapped place
  task automatic t_reset();
    xfer(0, IDX_TEN_CTRL, 8'h00);
    chk(d, 8'h21);
    chk({ten_on, ten_code, ten_mv}, {1'b0, 6'h21, mv(33)});
    chk(pwm, 3'h0);
    xfer(0, IDX_SUPPLY, 8'h00);
    chk(d, 8'h60);
    xfer(1, 8'h10, 8'hFF);
    xfer(0, 8'h10, 8'h00);
    chk(d, 8'h00);
    $display("test reset done");
  endtask

  // ten regulator: mapping, cap, enable, preset against immediate
  task automatic t_ten();
    xfer(1, IDX_TEN_CTRL, 8'h70);
    cw(2);
    chk({ten_on, ten_code, ten_mv}, {1'b1, 6'h30, mv(48)});
    xfer(1, IDX_TEN_CTRL, 8'h3F);
    cw(2);
    chk({ten_on, ten_code, ten_mv}, {1'b0, 6'h3F, mv(63)});
    xfer(1, IDX_TEN_CTRL, 8'hC5);
    cw(2);
    chk({ten_on, ten_code}, {1'b1, 6'h3F});
    pd <= 1'b1;
    cw(10);
    chk({ten_on, ten_code, ten_mv}, {1'b1, 6'h05, mv(5)});
    pd <= 1'b0;
    xfer(1, IDX_TEN_CTRL, 8'h41);
    cw(10);
    chk({ten_on, ten_code}, {1'b1, 6'h01});
    pd <= 1'b1;
    cw(10);
    chk(ten_on, 1'b0);
    pd <= 1'b0;
    cw(10);
    $display("test ten regulator done");
  endtask

  // ramp of one rail: hold, go, blocked write, self clear, pwm
  task automatic t_ramp(input int r);
    int n;
    xfer(1, 8'(IDX_CORE_BUCK + r), 8'h08);
    cw(2);
    chk(rail[r], 6'h00);
    xfer(1, IDX_SUPPLY, 8'(8'h60 | (1 << r)));
    xfer(0, IDX_SUPPLY, 8'h00);
    chk(d[r], 1'b1);
    if (r < 3) chk(pwm[r], 1'b1);
    xfer(1, 8'(IDX_CORE_BUCK + r), 8'h3F);
    n = 0;
    do begin
      xfer(0, IDX_SUPPLY, 8'h00);
      // short of its target the buck is still ramping, so pwm must be forced
      if (r < 3 && rail[r] !== 6'h08) chk(pwm[r], 1'b1);
      n++;
    end while (d[r] !== 1'b0 && n < 60);
    chk(d[r], 1'b0);
    chk(rail[r], 6'h08);
    if (r < 3) chk(pwm[r], 1'b0);
    xfer(0, 8'(IDX_CORE_BUCK + r), 8'h00);
    chk(d, 8'h08);
    $display("test ramp rail %0d done", r);
  endtask

  // linear two go is ignored under preset, then the lock bit
  task automatic t_preset_lock();
    xfer(1, IDX_LIN_TWO, 8'h85);
    xfer(1, IDX_SUPPLY, 8'h68);
    cw(60);
    chk(rail[3], 6'h08);
    xfer(1, IDX_SUPPLY, 8'hE0);
    xfer(1, IDX_TEN_CTRL, 8'h05);
    xfer(0, IDX_TEN_CTRL, 8'h00);
    chk(d, 8'h01);
    chk({ten_on, ten_code}, {1'b0, 6'h01});
    xfer(1, IDX_CORE_BUCK, 8'h10);
    xfer(0, IDX_CORE_BUCK, 8'h00);
    chk(d, 8'h08);
    $display("test preset and lock done");
  endtask

  // ************************************************************
  // verdict, main sequence and watchdog
  // ************************************************************
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ten();
    for (int r = 0; r < NUM_RAILS; r++) t_ramp(r);
    t_preset_lock();
    conclude();
  end

  // cuts a hang short well past the expected run
  initial begin
    #(25 * 20000);
    fails++;
    conclude();
  end
endmodule // regulator_voltage_ctrl_regs_test
`default_nettype wire
